// >>> jcra_tap_access.sv
/*
  Top of the test-port register access block: TAP controller, 48-bit
  instruction register, bypass bit, 67-bit access register, chain mux.
  Assumes tck is the link clock, trstN pulls the TAP to reset, and the
  transceiver TAP shares tck and tms.
*/
//
// Overview of operation
// - Access register is 67 bits: address 61:52, write flag 51, data 50:19.
// - Access register shifts least significant bit first, bit 66 last.
// - Write flag one writes the 32 data bits to the addressed register.
// - Write flag zero reads the addressed register and keeps its value.
// - Observation shift gives ready first, then error.
// - Read access shifts out 32 data bits after ready and error.
// - Test-port reads never disturb or stall bridge traffic.
// - Chain select high puts the transceiver TAP ahead of ours.
// - Global tri-state input forces all bidirectional pins to input.
// - TAP resets after five tms-high clocks or on test reset.
// - Unknown instruction codes act as bypass.
`timescale 1ns/1ns
`default_nettype none
`include "jcra_defs.svh"
module jcra_tap_access #(
    parameter int BIDIR_W = 8
) (
    input wire logic ref_clk, // Core clock, 100 MHz
    input wire logic reset, // Core sync reset, high
    input wire logic tck, // Test clock
    input wire logic trstN, // Test reset, low
    input wire logic tms, // Test mode select
    input wire logic tdi, // Test data in
    output logic tdo, // Test data out
    output logic tdoOeN, // Low while tdo drives
    input wire logic tap_chain_select, // Daisy chain when high
    input wire logic xcvrTdo, // Transceiver TAP data out
    output logic xcvrTdi, // Transceiver TAP data in
    input wire logic global_tristate_control, // Tri-state pin
    input wire logic [BIDIR_W-1:0] coreOeN, // Core pad enables
    output logic [BIDIR_W-1:0] bidirOeN, // Pad enables, low drives
    output logic cfgReq, // Register access request
    output logic cfgWe, // Write when high
    output logic [9:0] cfgAddr, // Dword index
    output logic [31:0] cfgWdata, // Write data
    input wire logic [31:0] cfgRdata, // Read data
    input wire logic cfgAck, // Access done pulse
    input wire logic cfgErr // Access failed
);
    jcra_pkg::jcra_tap_t s_r, s_nxt;
    jcra_xfer_if xfer();
    logic serialIn, irAcc, ready, tdo_r, tdoOeN_r;

    // Standard TAP state graph, steered by tms on each rising tck
    function automatic jcra_pkg::jcra_tap_state_t tapNext(
        input jcra_pkg::jcra_tap_state_t st, input logic m);
        case (st)
            jcra_pkg::TLR: tapNext = m ? jcra_pkg::TLR : jcra_pkg::RTI;
            jcra_pkg::RTI: tapNext = m ? jcra_pkg::SELDR : jcra_pkg::RTI;
            jcra_pkg::SELDR: tapNext = m ? jcra_pkg::SELIR : jcra_pkg::CAPDR;
            jcra_pkg::CAPDR: tapNext = m ? jcra_pkg::EX1DR : jcra_pkg::SHDR;
            jcra_pkg::SHDR: tapNext = m ? jcra_pkg::EX1DR : jcra_pkg::SHDR;
            jcra_pkg::EX1DR: tapNext = m ? jcra_pkg::UPDR : jcra_pkg::PADR;
            jcra_pkg::PADR: tapNext = m ? jcra_pkg::EX2DR : jcra_pkg::PADR;
            jcra_pkg::EX2DR: tapNext = m ? jcra_pkg::UPDR : jcra_pkg::SHDR;
            jcra_pkg::UPDR: tapNext = m ? jcra_pkg::SELDR : jcra_pkg::RTI;
            jcra_pkg::SELIR: tapNext = m ? jcra_pkg::TLR : jcra_pkg::CAPIR;
            jcra_pkg::CAPIR: tapNext = m ? jcra_pkg::EX1IR : jcra_pkg::SHIR;
            jcra_pkg::SHIR: tapNext = m ? jcra_pkg::EX1IR : jcra_pkg::SHIR;
            jcra_pkg::EX1IR: tapNext = m ? jcra_pkg::UPIR : jcra_pkg::PAIR;
            jcra_pkg::PAIR: tapNext = m ? jcra_pkg::EX2IR : jcra_pkg::PAIR;
            jcra_pkg::EX2IR: tapNext = m ? jcra_pkg::UPIR : jcra_pkg::SHIR;
            jcra_pkg::UPIR: tapNext = m ? jcra_pkg::SELDR : jcra_pkg::RTI;
            default: tapNext = jcra_pkg::TLR;
        endcase
    endfunction

    // Chain mux: transceiver TAP sits between the pin and our TAP
    assign serialIn = s_r.chainSel ? xcvrTdo : tdi;
    assign xcvrTdi = tdi;
    // Any code but the access code falls back to the bypass bit
    assign irAcc = (s_r.ir == `JCRA_IR_ACCESS);
    // Idle when our request toggle matches the returned ack toggle
    assign ready = (s_r.reqTog == s_r.ackSync);

    // Next state of the test-clock side
    always_comb begin
        s_nxt = s_r;
        s_nxt.st = tapNext(s_r.st, tms);
        s_nxt.chainMeta = tap_chain_select;
        s_nxt.chainSel = s_r.chainMeta;
        s_nxt.ackMeta = xfer.ackTog;
        s_nxt.ackSync = s_r.ackMeta;
        case (s_r.st)
            jcra_pkg::TLR: s_nxt.ir = `JCRA_IR_BYPASS;
            jcra_pkg::CAPIR: s_nxt.irSh = `JCRA_IR_CAPTURE;
            jcra_pkg::SHIR: s_nxt.irSh = {serialIn, s_r.irSh[`JCRA_IR_LEN-1:1]};
            jcra_pkg::UPIR: s_nxt.ir = s_r.irSh;
            jcra_pkg::CAPDR: begin
                s_nxt.byp = 1'b0;
                if (irAcc) begin
                    // Status and data of the last access; unused bits zero
                    s_nxt.dr = '0;
                    s_nxt.dr[`JCRA_OUT_READY] = ready;
                    if (ready) begin
                        s_nxt.dr[`JCRA_OUT_ERR] = xfer.err;
                        s_nxt.dr[`JCRA_OUT_RD_MSB:`JCRA_OUT_RD_LSB] =
                            xfer.rdata;
                    end
                end
            end
            jcra_pkg::SHDR: begin
                if (irAcc)
                    s_nxt.dr = {serialIn, s_r.dr[`JCRA_DR_LEN-1:1]};
                else
                    s_nxt.byp = serialIn;
            end
            jcra_pkg::UPDR: begin
                // A busy access ignores a new word; the data stays bundled
                if (irAcc && ready) begin
                    s_nxt.addr = s_r.dr[`JCRA_ADDR_MSB:`JCRA_ADDR_LSB];
                    s_nxt.rw = s_r.dr[`JCRA_RW_BIT];
                    s_nxt.wdata = s_r.dr[`JCRA_WDATA_MSB:`JCRA_WDATA_LSB];
                    s_nxt.reqTog = ~s_r.reqTog;
                end
            end
            default: ;
        endcase
    end

    // Test-clock state register, reset by the test reset pin
    always_ff @(posedge tck or negedge trstN) begin
        if (!trstN) begin
            s_r <= '0;
            s_r.st <= jcra_pkg::TLR;
            s_r.ir <= `JCRA_IR_BYPASS;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Output stage on the falling edge, as the boundary-scan timing needs
    always_ff @(negedge tck or negedge trstN) begin
        if (!trstN) begin
            tdo_r <= 1'b0;
            tdoOeN_r <= 1'b1;
        end else begin
            tdoOeN_r <= !(s_r.st == jcra_pkg::SHIR || s_r.st == jcra_pkg::SHDR);
            if (s_r.st == jcra_pkg::SHIR)
                tdo_r <= s_r.irSh[0];
            else
                tdo_r <= irAcc ? s_r.dr[0] : s_r.byp;
        end
    end

    assign tdo = tdo_r;
    assign tdoOeN = tdoOeN_r;
    assign xfer.reqTog = s_r.reqTog;
    assign xfer.rw = s_r.rw;
    assign xfer.addr = s_r.addr;
    assign xfer.wdata = s_r.wdata;

    // Reference-clock side of the access
    jcra_cfg_port #(
        .BIDIR_W(BIDIR_W)
    ) u_cfg (
        .ref_clk(ref_clk),
        .reset(reset),
        .xfer(xfer.coreSide),
        .globalTristateControl(global_tristate_control),
        .coreOeN(coreOeN),
        .bidirOeN(bidirOeN),
        .cfgReq(cfgReq),
        .cfgWe(cfgWe),
        .cfgAddr(cfgAddr),
        .cfgWdata(cfgWdata),
        .cfgRdata(cfgRdata),
        .cfgAck(cfgAck),
        .cfgErr(cfgErr)
    );

    tms_reset_a: assert property (@(posedge tck) disable iff (!trstN)
        tms [*5] |=> s_r.st == jcra_pkg::TLR)
        else $error("five tms-high clocks did not reset the TAP");
    cap_ready_a: assert property (@(posedge tck) disable iff (!trstN)
        (s_r.st == jcra_pkg::CAPDR && irAcc) |=> s_r.dr[0] == $past(ready)
        && (s_r.dr[1] == ($past(ready) && $past(xfer.err))))
        else $error("ready or error bit not captured");
    cap_rdata_a: assert property (@(posedge tck) disable iff (!trstN)
        (s_r.st == jcra_pkg::CAPDR && irAcc && ready) |=>
        s_r.dr[`JCRA_OUT_RD_MSB:`JCRA_OUT_RD_LSB] == $past(xfer.rdata))
        else $error("read data not captured");
    shift_lsb_a: assert property (@(posedge tck) disable iff (!trstN)
        (s_r.st == jcra_pkg::SHDR && irAcc) |=> s_r.dr[65:0] ==
        $past(s_r.dr[66:1]) && s_r.dr[66] == $past(serialIn))
        else $error("access register not shifted lsb first");
    update_req_a: assert property (@(posedge tck) disable iff (!trstN)
        (s_r.st == jcra_pkg::UPDR && irAcc && ready) |=>
        s_r.reqTog != $past(s_r.reqTog) && s_r.rw == $past(s_r.dr[51])
        && s_r.addr == $past(s_r.dr[61:52]))
        else $error("update did not launch the access");
    bypass_path_a: assert property (@(posedge tck) disable iff (!trstN)
        (s_r.st == jcra_pkg::SHDR && !irAcc) |=> tdo == s_r.byp)
        else $error("unknown instruction not routed to bypass");
    chain_sel_a: assert property (@(posedge tck) disable iff (!trstN)
        (tap_chain_select [*3]) |=> serialIn == xcvrTdo)
        else $error("chain select not honoured");
    acc_cov_c: cover property (@(posedge tck)
        s_r.st == jcra_pkg::UPDR && irAcc && ready);
    chain_cov_c: cover property (@(posedge tck) s_r.chainSel && irAcc);
endmodule // jcra_tap_access
`default_nettype wire

// >>> jcra_defs.svh
/*
  Constants for the test-port register access block: instruction codes,
  access word layout and timing counts.
  Assumes inclusion by bare name from package and modules.
*/
`ifndef JCRA_DEFS_SVH
`define JCRA_DEFS_SVH
`define JCRA_IR_LEN 48
`define JCRA_IR_ACCESS 48'hFFFF_FFFF_FFFD
`define JCRA_IR_BYPASS 48'hFFFF_FFFF_FFFF
`define JCRA_IR_CAPTURE 48'h0000_0000_0001
`define JCRA_DR_LEN 67
`define JCRA_ADDR_MSB 61
`define JCRA_ADDR_LSB 52
`define JCRA_RW_BIT 51
`define JCRA_WDATA_MSB 50
`define JCRA_WDATA_LSB 19
`define JCRA_OUT_READY 0
`define JCRA_OUT_ERR 1
`define JCRA_OUT_RD_LSB 2
`define JCRA_OUT_RD_MSB 33
`define JCRA_REF_PERIOD_NS 10
`define JCRA_ACK_TIMEOUT_NS 320
`define JCRA_ACK_TIMEOUT_CYC \
    (`JCRA_ACK_TIMEOUT_NS / `JCRA_REF_PERIOD_NS)
`endif

// >>> jcra_pkg.sv
/*
  Types of the test-port register access block.
  Assumes jcra_defs.svh is on the include path.
*/
`include "jcra_defs.svh"
package jcra_pkg;
    typedef enum logic [15:0] {
        TLR = 16'h0001, RTI = 16'h0002, SELDR = 16'h0004,
        CAPDR = 16'h0008, SHDR = 16'h0010, EX1DR = 16'h0020,
        PADR = 16'h0040, EX2DR = 16'h0080, UPDR = 16'h0100,
        SELIR = 16'h0200, CAPIR = 16'h0400, SHIR = 16'h0800,
        EX1IR = 16'h1000, PAIR = 16'h2000, EX2IR = 16'h4000,
        UPIR = 16'h8000
    } jcra_tap_state_t;

    typedef enum logic [1:0] {
        CIDLE = 2'h1, CBUSY = 2'h2
    } jcra_core_state_t;

    typedef struct packed {
        jcra_tap_state_t st;
        logic [`JCRA_IR_LEN-1:0] ir;
        logic [`JCRA_IR_LEN-1:0] irSh;
        logic [`JCRA_DR_LEN-1:0] dr;
        logic byp;
        logic reqTog;
        logic rw;
        logic [9:0] addr;
        logic [31:0] wdata;
        logic chainMeta;
        logic chainSel;
        logic ackMeta;
        logic ackSync;
    } jcra_tap_t;
endpackage

// >>> jcra_xfer_if.sv
/*
  Access request and answer between the test-clock side and the
  reference-clock side. Toggle handshake with bundled data.
  Assumes each side holds its data until the other side answers.
*/
`timescale 1ns/1ns
`default_nettype none
interface jcra_xfer_if;
    logic reqTog;
    logic rw;
    logic [9:0] addr;
    logic [31:0] wdata;
    logic ackTog;
    logic [31:0] rdata;
    logic err;
    modport tapSide(output reqTog, rw, addr, wdata,
                    input ackTog, rdata, err);
    modport coreSide(input reqTog, rw, addr, wdata,
                     output ackTog, rdata, err);
endinterface
`default_nettype wire

// >>> jcra_cfg_port.sv
/*
  Reference-clock side: turns an access request into one configuration
  register cycle and returns data and status; global tri-state control.
  Assumes the register bank answers each cfgReq with a cfgAck pulse.
*/
`timescale 1ns/1ns
`default_nettype none
`include "jcra_defs.svh"
module jcra_cfg_port #(
    parameter int BIDIR_W = 8
) (
    input wire logic ref_clk, // Core clock
    input wire logic reset, // Sync reset, high
    jcra_xfer_if.coreSide xfer, // Handshake to test side
    input wire logic globalTristateControl, // Tri-state pin
    input wire logic [BIDIR_W-1:0] coreOeN, // Core enables, low drives
    output logic [BIDIR_W-1:0] bidirOeN, // Pad enables, low drives
    output logic cfgReq, // Access request level
    output logic cfgWe, // Write when high
    output logic [9:0] cfgAddr, // Dword index
    output logic [31:0] cfgWdata, // Write data
    input wire logic [31:0] cfgRdata, // Read data
    input wire logic cfgAck, // Access done pulse
    input wire logic cfgErr // Access failed
);
    typedef struct packed {
        jcra_pkg::jcra_core_state_t st;
        logic reqMeta, reqSync, reqLast, ackTog, err;
        logic [31:0] rdata;
        logic req, we;
        logic [9:0] addr;
        logic [31:0] wdata;
        logic [7:0] timer;
        logic triMeta, triSync;
        logic [BIDIR_W-1:0] oeN;
    } jcra_core_t;

    localparam logic [7:0] TIMEOUT = 8'(`JCRA_ACK_TIMEOUT_CYC);
    jcra_core_t s_r, s_nxt;

    // Next state; a lost ack would hang the test side, hence the timer
    always_comb begin
        s_nxt = s_r;
        s_nxt.reqMeta = xfer.reqTog;
        s_nxt.reqSync = s_r.reqMeta;
        s_nxt.triMeta = globalTristateControl;
        s_nxt.triSync = s_r.triMeta;
        s_nxt.oeN = s_r.triSync ? '1 : coreOeN;
        case (s_r.st)
            jcra_pkg::CIDLE: begin
                if (s_r.reqSync != s_r.reqLast) begin
                    s_nxt.reqLast = s_r.reqSync;
                    s_nxt.req = 1'b1;
                    s_nxt.we = xfer.rw;
                    s_nxt.addr = xfer.addr;
                    s_nxt.wdata = xfer.wdata;
                    s_nxt.timer = TIMEOUT;
                    s_nxt.st = jcra_pkg::CBUSY;
                end
            end
            jcra_pkg::CBUSY: begin
                if (cfgAck || s_r.timer == 8'h00) begin
                    s_nxt.req = 1'b0;
                    s_nxt.we = 1'b0;
                    // Only reads capture data, writes leave it as zero
                    s_nxt.rdata = (cfgAck && !s_r.we) ? cfgRdata : '0;
                    s_nxt.err = cfgAck ? cfgErr : 1'b1;
                    s_nxt.ackTog = ~s_r.ackTog;
                    s_nxt.st = jcra_pkg::CIDLE;
                end else begin
                    s_nxt.timer = s_r.timer - 8'h01;
                end
            end
            default: s_nxt.st = jcra_pkg::CIDLE;
        endcase
    end

    // State register
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s_r <= '0;
            s_r.st <= jcra_pkg::CIDLE;
            s_r.oeN <= '1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from the state register
    assign xfer.ackTog = s_r.ackTog;
    assign xfer.rdata = s_r.rdata;
    assign xfer.err = s_r.err;
    assign bidirOeN = s_r.oeN;
    assign cfgReq = s_r.req;
    assign cfgWe = s_r.we;
    assign cfgAddr = s_r.addr;
    assign cfgWdata = s_r.wdata;

    tristate_in_a: assert property (@(posedge ref_clk) disable iff (reset)
        globalTristateControl [*3] |=> &bidirOeN)
        else $error("bidir pins not forced to input");
    read_no_write_a: assert property (@(posedge ref_clk)
        disable iff (reset) (cfgReq && !s_r.we) |-> !cfgWe ##1 !cfgWe)
        else $error("read access drove a write strobe");
    req_issue_a: assert property (@(posedge ref_clk) disable iff (reset)
        $changed(xfer.reqTog) |-> ##[1:4] (cfgReq && cfgWe == xfer.rw))
        else $error("access request not issued");
    ack_return_a: assert property (@(posedge ref_clk) disable iff (reset)
        (cfgReq && cfgAck && !cfgWe) |=> (xfer.rdata == $past(cfgRdata))
        && xfer.ackTog != $past(xfer.ackTog))
        else $error("read data not returned");
    write_cov_c: cover property (@(posedge ref_clk) cfgReq && cfgWe && cfgAck);
    read_cov_c: cover property (@(posedge ref_clk) cfgReq && !cfgWe && cfgAck);
    timeout_cov_c: cover property (@(posedge ref_clk)
        s_r.st == jcra_pkg::CBUSY && s_r.timer == 8'h00);
endmodule // jcra_cfg_port
`default_nettype wire

// >>> jcra_bank_model.sv
/*
  Behavioural configuration register bank that answers the access port.
  Assumes ref_clk and the access port's request/ack protocol: cfgReq
  level, one cfgAck pulse per access, cfgRdata and cfgErr read with it.
*/
`timescale 1ns/1ns
`default_nettype none
module jcra_bank_model (
    input wire logic ref_clk, // Core clock
    input wire logic reset, // Sync reset, high
    input wire logic cfgReq, // Access request level
    input wire logic cfgWe, // Write when high
    input wire logic [9:0] cfgAddr, // Dword index
    input wire logic [31:0] cfgWdata, // Write data
    output logic [31:0] cfgRdata, // Read data
    output logic cfgAck, // Access done pulse
    output logic cfgErr, // Access failed
    input wire logic [5:0] lat, // Cycles before answering
    input wire logic errOn, // Answer with error
    input wire logic noAck, // Never answer
    output logic [9:0] lastAddr // Last index served
);
    logic [31:0] mem [0:1023];
    logic [31:0] rdReg;
    logic [5:0] cnt;
    logic busy;
    // Clean bank so that a dropped write shows as zero
    initial begin
        for (int i = 0; i < 1024; i++) mem[i] = 32'h0000_0000;
    end
    // Lines are not held outside the ack cycle, so show the inverse
    assign cfgRdata = cfgAck ? rdReg : ~rdReg;
    assign cfgErr = cfgAck ? errOn : ~errOn;
    // One answer per request; the ack edge itself never restarts
    always @(posedge ref_clk) begin
        cfgAck <= 1'b0;
        if (reset) begin
            busy <= 1'b0;
            cnt <= 6'h00;
            rdReg <= 32'h0000_0000;
            lastAddr <= 10'h000;
        end else if (busy && !cfgReq) begin
            busy <= 1'b0;
        end else if (cfgReq && !busy && !cfgAck) begin
            busy <= 1'b1;
            cnt <= 6'h00;
        end else if (busy && cnt == lat && !noAck) begin
            cfgAck <= 1'b1;
            busy <= 1'b0;
            lastAddr <= cfgAddr;
            rdReg <= mem[cfgAddr];
            if (cfgWe) mem[cfgAddr] <= cfgWdata;
        end else if (busy) begin
            cnt <= cnt + 6'h01;
        end
    end
endmodule // jcra_bank_model
`default_nettype wire

// >>> tb_top.sv
/*
  Self-checking bench of the test-port register access block.
  Assumes the bank model beside it; the bench plays host and transceiver.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    localparam int LIMIT = 40000; // Tests need about 4400 ref cycles
    localparam logic [66:0] PAT = 67'hA5;
    logic ref_clk = 1'b0, reset = 1'b1, tck = 1'b0, trstN = 1'b1;
    logic tms = 1'b1, tdi = 1'b0, chainSel = 1'b0, gtc = 1'b0;
    logic errOn = 1'b0, noAck = 1'b0;
    logic [7:0] coreOeN = 8'h00;
    logic [5:0] lat = 6'h02;
    logic tdo, tdoOeN, xcvrTdi, xcvrTdo, cfgReq, cfgWe, cfgAck, cfgErr;
    logic [7:0] bidirOeN;
    logic [9:0] cfgAddr, lastAddr;
    logic [31:0] cfgWdata, cfgRdata;
    logic [66:0] o;
    int n_mismatch = 0, checked = 0, cyc = 0;

    always #5 ref_clk = ~ref_clk;
    // Stand-in transceiver inverts, so its place in the chain shows
    assign xcvrTdo = ~xcvrTdi;

    jcra_tap_access #(.BIDIR_W(8)) jcra_tap_access_i (.ref_clk(ref_clk),
        .reset(reset), .tck(tck), .trstN(trstN), .tms(tms), .tdi(tdi),
        .tdo(tdo), .tdoOeN(tdoOeN), .tap_chain_select(chainSel),
        .xcvrTdo(xcvrTdo), .xcvrTdi(xcvrTdi),
        .global_tristate_control(gtc), .coreOeN(coreOeN),
        .bidirOeN(bidirOeN), .cfgReq(cfgReq), .cfgWe(cfgWe),
        .cfgAddr(cfgAddr), .cfgWdata(cfgWdata), .cfgRdata(cfgRdata),
        .cfgAck(cfgAck), .cfgErr(cfgErr));
    jcra_bank_model jcra_bank_model_i (.ref_clk(ref_clk), .reset(reset),
        .cfgReq(cfgReq), .cfgWe(cfgWe), .cfgAddr(cfgAddr),
        .cfgWdata(cfgWdata), .cfgRdata(cfgRdata), .cfgAck(cfgAck),
        .cfgErr(cfgErr), .lat(lat), .errOn(errOn), .noAck(noAck),
        .lastAddr(lastAddr));

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input logic [66:0] got, exp, input string msg);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    // One test clock; tck stands still between calls
    task automatic tck_cycle(input logic m, input logic d, output logic q);
        tms <= m;
        tdi <= d;
        #16;
        q = tdo;
        tck = 1'b1;
        #16;
        tck = 1'b0;
    endtask

    task automatic idle(input int k);
        logic q;
        repeat (k) tck_cycle(1'b0, 1'b0, q);
    endtask

    // From Run-Test/Idle through one IR or DR scan and back, lsb first
    task automatic scan(input bit ir, input int n, input logic [66:0] din,
                        output logic [66:0] dout);
        logic q;
        dout = '0;
        tck_cycle(1'b1, 1'b0, q);
        if (ir) tck_cycle(1'b1, 1'b0, q);
        tck_cycle(1'b0, 1'b0, q);
        tck_cycle(1'b0, 1'b0, q);
        for (int i = 0; i < n; i++) begin
            tck_cycle(i == n - 1, din[i], q);
            dout[i] = q;
        end
        tck_cycle(1'b1, 1'b0, q);
        tck_cycle(1'b0, 1'b0, q);
    endtask

    function automatic logic [66:0] word(logic rw, logic [9:0] a,
                                         logic [31:0] d);
        return {5'h00, a, rw, d, 19'h0_0000};
    endfunction

    // Eight-bit scan through the one-bit path, inverted when chained
    task automatic byp_chk(input logic inv, input string msg);
        scan(1'b0, 8, PAT, o);
        chk(o[7:0], {PAT[6:0] ^ {7{inv}}, 1'b0}, msg);
    endtask

    task automatic set_bank(input logic e, input logic n, input logic [5:0] l);
        @(posedge ref_clk);
        errOn <= e;
        noAck <= n;
        lat <= l;
    endtask

    // Ceiling on the whole run
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            n_mismatch++;
            print_verdict();
        end
    end

    logic [9:0] adT [2] = '{10'h032, 10'h3FF}; // Byte 0x0C8 as dword index
    logic [31:0] dT [2] = '{32'hDEAD_BEEF, 32'h8000_0001};

    initial begin
        trstN <= 1'b0; // A real falling edge, so the TAP reset fires
        repeat (20) @(posedge ref_clk);
        #1;
        chk({tdoOeN, bidirOeN, cfgReq}, {1'b1, 8'hFF, 1'b0}, "reset");
        @(posedge ref_clk);
        reset <= 1'b0;
        trstN <= 1'b1;
        coreOeN <= 8'h5A;
        // Tri-state input overrides the core enables, then lets go
        repeat (4) @(posedge ref_clk);
        #1 chk(bidirOeN, 8'h5A, "pads follow core");
        @(posedge ref_clk) gtc <= 1'b1;
        repeat (4) @(posedge ref_clk);
        #1 chk(bidirOeN, 8'hFF, "pads forced input");
        @(posedge ref_clk) gtc <= 1'b0;
        repeat (4) @(posedge ref_clk);
        #1 chk(bidirOeN, 8'h5A, "pads released");
        $display("test tristate done");
        #3 idle(1);
        // IR scan captures 1, then an unknown code acts as bypass
        scan(1'b1, 48, {19'h0_0000, 48'h0000_1234_5678}, o);
        chk(o[47:0], 48'h0000_0000_0001, "ir capture");
        byp_chk(1'b0, "unknown code bypass");
        $display("test bypass done");
        scan(1'b1, 48, {19'h0_0000, 48'hFFFF_FFFF_FFFD}, o);
        for (int k = 0; k < 2; k++) begin
            scan(1'b0, 67, word(1'b1, adT[k], dT[k]), o);
            idle(20);
            scan(1'b0, 67, word(1'b0, adT[k], 32'h0000_0000), o);
            chk(o[33:0], 34'h1, "write status");
            chk(lastAddr, adT[k], "write index");
            idle(20);
            scan(1'b0, 67, word(1'b0, adT[k], 32'h0000_0000), o);
            chk(o, {33'h0, dT[k], 2'b01}, "read data");
            idle(20);
        end
        $display("test write read done");
        // Bank error, then timeout, then a slow but timely answer
        set_bank(1'b1, 1'b0, 6'h00);
        scan(1'b0, 67, word(1'b0, 10'h005, 32'h0000_0000), o);
        idle(20);
        set_bank(1'b0, 1'b1, 6'h00);
        scan(1'b0, 67, word(1'b0, 10'h006, 32'h0000_0000), o);
        chk(o[1:0], 2'b11, "bank error");
        idle(20);
        set_bank(1'b0, 1'b0, 6'h1C);
        scan(1'b0, 67, word(1'b0, 10'h032, 32'h0000_0000), o);
        chk(o[33:0], 34'h3, "timeout error");
        idle(20);
        // Keep the slow bank so the next short scan finds the write busy
        set_bank(1'b0, 1'b0, 6'h1C);
        scan(1'b0, 67, word(1'b1, 10'h010, 32'h1234_5678), o);
        chk(o[33:0], {dT[0], 2'b01}, "slow answer");
        $display("test errors done");
        // Observe and update at once: not ready, so the update is dropped
        scan(1'b0, 2, word(1'b1, 10'h011, 32'hFFFF_FFFF), o);
        chk(o[33:0], 34'h0, "not ready");
        idle(20);
        scan(1'b0, 67, word(1'b0, 10'h010, 32'h0000_0000), o);
        chk(o[1:0], 2'b01, "retry ready");
        chk(lastAddr, 10'h010, "busy word dropped");
        idle(20);
        scan(1'b0, 67, word(1'b0, 10'h011, 32'h0000_0000), o);
        chk(o[33:0], {32'h1234_5678, 2'b01}, "read after retry");
        idle(20);
        scan(1'b0, 67, word(1'b0, 10'h011, 32'h0000_0000), o);
        chk(o[33:0], 34'h1, "dropped write absent");
        $display("test not ready done");
        // Five tms-high clocks restore bypass
        idle(20);
        repeat (5) tck_cycle(1'b1, 1'b0, o[0]);
        idle(1);
        byp_chk(1'b0, "tms reset bypass");
        @(posedge ref_clk) chainSel <= 1'b1;
        byp_chk(1'b1, "chained path");
        chk(xcvrTdi, tdi, "transceiver input");
        @(posedge ref_clk) chainSel <= 1'b0;
        byp_chk(1'b0, "chain off");
        $display("test chain done");
        print_verdict();
    end
endmodule // tb_top
`default_nettype wire
